// ===== logic/vih_pkg.sv
// Constants and types of the vectored interrupt hub.
// Assumes a single 20 MHz system clock and an active-low asynchronous reset.
//
// Summary of operation
// [RL1] Thirty-two vectors, thirteen fed by start-logic pins
// [RL2] Four priority levels, masking, software-set pending; level 3 requests are never taken, as idle is level 3
// [RL3] Exceptions and interrupts share one priority scheme
// [RL4] One request line per peripheral
// [RL5] Each flag ORs several event sources
// [RL6] Pins request on level, rise, fall, both
// [RL7] Vector table base can be remapped
// [RL8] Fast entry, late higher request preempts
// [RL9] Interrupt pins leave reset as pulled-up inputs
// [RL10] Deep power-down ignores reset, wake pin exits; the pin sense unit still resets on RSTN
// [RL11] Software maps pins before enabling interrupts
// [RL12] Level pending follows pin, edge latches
package vih_pkg;
  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_IRQ    = 32;
  localparam int NUM_START  = 13;
  localparam int NUM_PINS   = 25;
  localparam int NUM_PERIPH = NUM_IRQ - NUM_START;
  localparam int NUM_FLAGS  = 4;
  localparam int NUM_SRCS   = 2;
  localparam int NUM_EXC    = 4;
  localparam int PRIO_W     = 2;
  localparam int VEC_W      = 6;
  localparam int ADDR_W     = 32;
  // ----------------------------------------------------------------
  // Encodings and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] SENSE_LEVEL   = 2'h0;
  localparam logic [1:0] SENSE_RISE    = 2'h1;
  localparam logic [1:0] SENSE_FALL    = 2'h2;
  localparam logic [1:0] SENSE_BOTH    = 2'h3;
  localparam logic [PRIO_W-1:0] PRIO_IDLE = 2'h3;
  localparam logic [ADDR_W-1:0] VTOR_RST  = 32'h0000_0000;
  localparam logic [VEC_W-1:0]  IRQ_VEC0  = 6'h10;
  localparam logic [VEC_W-1:0]  NO_VEC    = 6'h00;
  localparam logic              PULLUP_RST = 1'b1;
  localparam logic [1:0]        VEC_BYTES_LOG2 = 2'h2;

  typedef enum logic [1:0] {VIH_RUN, VIH_ENTRY, VIH_ACTIVE, VIH_DPD}
    vih_state_t;
endpackage : vih_pkg

// ===== logic/vih_pin_if.sv
// Pin sense interface between the hub and its pin sense unit.
// Assumes both ends run on the system clock.
`timescale 1ns/10ps
interface vih_pin_if;
  logic [vih_pkg::NUM_PINS-1:0]   pin_lvl;
  logic [2*vih_pkg::NUM_PINS-1:0] sense;
  logic [vih_pkg::NUM_PINS-1:0]   clr;
  logic [vih_pkg::NUM_PINS-1:0]   pend;
  modport hub (output pin_lvl, output sense, output clr, input pend);
  modport unit (input pin_lvl, input sense, input clr, output pend);
endinterface : vih_pin_if

// ===== logic/vih_pin_sense.sv
// Per-pin level and edge detection for GPIO interrupt requests.
// Assumes pin levels are already synchronous to the clock.
`timescale 1ns/10ps
module vih_pin_sense (
  input  wire logic clk,
  input  wire logic rst_n,
  vih_pin_if.unit   pif
);
  genvar g;
  generate
    for (g = 0; g < vih_pkg::NUM_PINS; g++) begin : g_pin
      logic       prev_reg;
      logic       edge_reg;
      wire  [1:0] mode = pif.sense[2*g+1:2*g];
      wire        rise = pif.pin_lvl[g] & ~prev_reg;
      wire        fall = ~pif.pin_lvl[g] & prev_reg;
      // [RL6] Edge selection
      wire        hit  = (mode == vih_pkg::SENSE_RISE) ? rise :
                         (mode == vih_pkg::SENSE_FALL) ? fall :
                         (mode == vih_pkg::SENSE_BOTH) ? (rise | fall) :
                         1'b0;
      wire        edge_next = hit | (edge_reg & ~pif.clr[g]);
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          prev_reg <= vih_pkg::PULLUP_RST;
          edge_reg <= 1'b0;
        end else begin
          prev_reg <= pif.pin_lvl[g];
          // [RL12] Edge latches, set wins
          edge_reg <= edge_next;
        end
      end
      // [RL12] Level follows pin
      assign pif.pend[g] = (mode == vih_pkg::SENSE_LEVEL) ?
                           pif.pin_lvl[g] : edge_reg;
    end
  endgenerate
endmodule : vih_pin_sense

// ===== logic/vih_hub.sv
// Top of the vectored interrupt hub: pending, enable, priority, vectoring.
// Assumes the core takes a vector on VEC_ACK and ends service on EOI.
`timescale 1ns/10ps
module vih_hub (
  input  wire logic                        CLK_SYS,
  input  wire logic                        RSTN,
  input  wire logic                        WAKE_PIN,
  input  wire logic                        DPD_REQ,
  input  wire logic [vih_pkg::NUM_EXC-1:0] EXC_REQ,
  input  wire logic [vih_pkg::NUM_PERIPH*vih_pkg::NUM_FLAGS*
                     vih_pkg::NUM_SRCS-1:0] PERIPH_SRC,
  input  wire logic [vih_pkg::NUM_PINS-1:0] PIN_IN,
  input  wire logic [2*vih_pkg::NUM_PINS-1:0] PIN_SENSE,
  input  wire logic [vih_pkg::NUM_PINS-1:0] PIN_CLR,
  input  wire logic [4:0]                  START_SEL [vih_pkg::NUM_START],
  input  wire logic [vih_pkg::NUM_IRQ-1:0] IRQ_EN,
  input  wire logic [vih_pkg::NUM_IRQ-1:0] SW_SET,
  input  wire logic [vih_pkg::NUM_IRQ-1:0] SW_CLR,
  input  wire logic [2*vih_pkg::NUM_IRQ-1:0] IRQ_PRIO,
  input  wire logic [vih_pkg::ADDR_W-1:0]  VTOR_IN,
  input  wire logic                        VTOR_WR,
  input  wire logic                        VEC_ACK,
  input  wire logic                        EOI,
  output logic                             IRQ_REQ,
  output logic [vih_pkg::VEC_W-1:0]        IRQ_VEC,
  output logic [vih_pkg::ADDR_W-1:0]       VEC_ADDR,
  output logic [vih_pkg::PRIO_W-1:0]       CUR_PRIO,
  output logic [vih_pkg::NUM_IRQ-1:0]      PEND_OUT,
  output logic [vih_pkg::NUM_PINS-1:0]     PIN_PULLUP,
  output logic [vih_pkg::NUM_PINS-1:0]     PIN_OE,
  output logic                             DPD_ACTIVE,
  output logic                             CHIP_RST
);
  // ----------------------------------------------------------------
  // Pin sense
  // ----------------------------------------------------------------
  vih_pin_if pif ();
  assign pif.pin_lvl = PIN_IN;
  assign pif.sense   = PIN_SENSE;
  assign pif.clr     = PIN_CLR;
  vih_pin_sense u_sense (
    .clk   (CLK_SYS),
    .rst_n (RSTN),
    .pif   (pif.unit)
  );

  // ----------------------------------------------------------------
  // Request sources
  // ----------------------------------------------------------------
  localparam int FS = vih_pkg::NUM_FLAGS * vih_pkg::NUM_SRCS;
  logic [vih_pkg::NUM_IRQ-1:0] raw_req;
  genvar p;
  generate
    for (p = 0; p < vih_pkg::NUM_PERIPH; p++) begin : g_per
      logic [vih_pkg::NUM_FLAGS-1:0] flag;
      genvar f;
      for (f = 0; f < vih_pkg::NUM_FLAGS; f++) begin : g_flag
        // [RL5] Flag ORs sources
        assign flag[f] = |PERIPH_SRC[p*FS+f*vih_pkg::NUM_SRCS +:
                                     vih_pkg::NUM_SRCS];
      end
      // [RL4] One line per peripheral
      assign raw_req[vih_pkg::NUM_START+p] = |flag;
    end
    for (p = 0; p < vih_pkg::NUM_START; p++) begin : g_start
      // [RL1] Start-logic pin inputs
      assign raw_req[p] = pif.pend[START_SEL[p]];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Pending and arbitration
  // ----------------------------------------------------------------
  vih_pkg::vih_state_t state_reg, state_next;
  logic [vih_pkg::NUM_IRQ-1:0] pend_reg;
  logic [vih_pkg::NUM_IRQ-1:0] act_reg;
  logic [vih_pkg::PRIO_W-1:0]  cur_reg;
  logic [vih_pkg::VEC_W-1:0]   sel_reg;
  logic [vih_pkg::ADDR_W-1:0]  vtor_reg;

  logic [vih_pkg::NUM_IRQ-1:0] take_clr;
  // [RL2] Software set and clear, set wins
  wire  [vih_pkg::NUM_IRQ-1:0] pend_next =
    raw_req | SW_SET | (pend_reg & ~SW_CLR & ~take_clr);

  // [RL3] Exceptions rank above all interrupts
  logic                        best_hit;
  logic                        best_exc;
  logic [vih_pkg::VEC_W-1:0]   best_vec;
  logic [vih_pkg::PRIO_W-1:0]  best_pri;
  always_comb begin
    best_hit = 1'b0;
    best_exc = 1'b0;
    best_vec = vih_pkg::NO_VEC;
    best_pri = vih_pkg::PRIO_IDLE;
    for (int i = vih_pkg::NUM_IRQ - 1; i >= 0; i--) begin
      // [RL2] Mask at and below current level
      if (pend_reg[i] && IRQ_EN[i] && !act_reg[i] &&
          IRQ_PRIO[2*i +: 2] < cur_reg &&
          (!best_hit || IRQ_PRIO[2*i +: 2] <= best_pri)) begin
        best_hit = 1'b1;
        best_pri = IRQ_PRIO[2*i +: 2];
        best_vec = vih_pkg::IRQ_VEC0 + vih_pkg::VEC_W'(i);
      end
    end
    for (int e = vih_pkg::NUM_EXC - 1; e >= 0; e--) begin
      if (EXC_REQ[e]) begin
        best_hit = 1'b1;
        best_exc = 1'b1;
        best_pri = 2'h0;
        best_vec = vih_pkg::VEC_W'(e + 2);
      end
    end
  end

  wire take = (state_reg == vih_pkg::VIH_ENTRY) && VEC_ACK;
  wire [vih_pkg::VEC_W-1:0] irq_idx = sel_reg - vih_pkg::IRQ_VEC0;
  assign take_clr = (take && sel_reg >= vih_pkg::IRQ_VEC0) ?
                    (32'h0000_0001 << irq_idx[4:0]) : 32'h0000_0000;
  // [RL7] Vector fetch through remap base
  wire [vih_pkg::ADDR_W-1:0] addr_next =
    vtor_reg + ({26'h0, best_vec} << vih_pkg::VEC_BYTES_LOG2);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      vih_pkg::VIH_RUN: begin
        if (DPD_REQ) begin
          state_next = vih_pkg::VIH_DPD;
        end else if (best_hit) begin
          state_next = vih_pkg::VIH_ENTRY;
        end
      end
      vih_pkg::VIH_ENTRY: begin
        if (VEC_ACK) begin
          state_next = vih_pkg::VIH_ACTIVE;
        end
      end
      vih_pkg::VIH_ACTIVE: begin
        if (best_hit) begin
          state_next = vih_pkg::VIH_ENTRY;
        end else if (EOI) begin
          state_next = vih_pkg::VIH_RUN;
        end
      end
      vih_pkg::VIH_DPD: begin
        state_next = vih_pkg::VIH_DPD;
      end
      default: state_next = vih_pkg::VIH_RUN;
    endcase
  end

  // ----------------------------------------------------------------
  // State registers; deep power-down holds against RSTN
  // ----------------------------------------------------------------
  // [RL10] Reset ignored in power-down
  wire core_rst_n = RSTN | (state_reg == vih_pkg::VIH_DPD);
  wire dpd_now    = state_reg == vih_pkg::VIH_DPD;

  always_ff @(posedge CLK_SYS or negedge core_rst_n) begin
    if (!core_rst_n) begin
      vtor_reg <= vih_pkg::VTOR_RST;
    end else if (VTOR_WR) begin
      // [RL7] Remap base load
      vtor_reg <= VTOR_IN;
    end
  end

  always_ff @(posedge CLK_SYS or negedge core_rst_n) begin
    if (!core_rst_n) begin
      state_reg <= vih_pkg::VIH_RUN;
    end else if (dpd_now && !WAKE_PIN) begin
      // [RL10] Wake pin exits
      state_reg <= vih_pkg::VIH_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge CLK_SYS or negedge core_rst_n) begin
    if (!core_rst_n) begin
      pend_reg <= 32'h0000_0000;
      act_reg  <= 32'h0000_0000;
      cur_reg  <= vih_pkg::PRIO_IDLE;
      sel_reg  <= vih_pkg::NO_VEC;
    end else begin
      pend_reg <= pend_next;
      if (take) begin
        act_reg <= act_reg | take_clr;
      end else if (EOI && state_reg == vih_pkg::VIH_ACTIVE) begin
        act_reg <= 32'h0000_0000;
        cur_reg <= vih_pkg::PRIO_IDLE;
      end
      // [RL8] Late arrival updates vector
      if (best_hit && (state_reg != vih_pkg::VIH_DPD)) begin
        sel_reg <= best_vec;
        if (!best_exc || take) begin
          cur_reg <= take ? best_pri : cur_reg;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  // [RL10] Outputs ignore RSTN in power-down
  always_ff @(posedge CLK_SYS or negedge core_rst_n) begin
    if (!core_rst_n) begin
      IRQ_REQ    <= 1'b0;
      IRQ_VEC    <= vih_pkg::NO_VEC;
      VEC_ADDR   <= vih_pkg::VTOR_RST;
      CUR_PRIO   <= vih_pkg::PRIO_IDLE;
      PEND_OUT   <= 32'h0000_0000;
      // [RL9] Pulled-up inputs at reset
      PIN_PULLUP <= {vih_pkg::NUM_PINS{vih_pkg::PULLUP_RST}};
      PIN_OE     <= 25'h0000000;
      DPD_ACTIVE <= 1'b0;
      CHIP_RST   <= 1'b1;
    end else begin
      IRQ_REQ    <= (state_next == vih_pkg::VIH_ENTRY);
      if (best_hit) begin
        IRQ_VEC  <= best_vec;
        VEC_ADDR <= addr_next;
      end
      CUR_PRIO   <= cur_reg;
      PEND_OUT   <= pend_reg;
      PIN_PULLUP <= {vih_pkg::NUM_PINS{vih_pkg::PULLUP_RST}};
      PIN_OE     <= 25'h0000000;
      DPD_ACTIVE <= dpd_now;
      CHIP_RST   <= dpd_now && !WAKE_PIN;
    end
  end
endmodule : vih_hub

// ===== tb/vih_core_model.sv
// Behavioural core that takes offered vectors and ends service.
// Assumes the hub holds IRQ_REQ until it sees the acknowledge.
`timescale 1ns/10ps
module vih_core_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       irq_req,
  input  wire logic       hold,
  input  wire logic [1:0] lag,
  output logic            vec_ack,
  output logic            eoi
);
  // ------------------------------------------------------------
  // Vector take and service
  // ------------------------------------------------------------
  initial begin
    vec_ack = 1'h0;
    eoi     = 1'h0;
  end
  always begin
    @(posedge clk);
    if (rst_n && irq_req && !hold) begin
      repeat (lag) @(posedge clk);
      vec_ack <= 1'h1;
      @(posedge clk);
      vec_ack <= 1'h0;
      repeat (4) @(posedge clk);
      eoi <= 1'h1;
      @(posedge clk);
      eoi <= 1'h0;
    end
  end
endmodule : vih_core_model

// ===== tb/vih_hub_chk.sv
// Port-level assertions for the vectored interrupt hub.
// Bound into vih_hub; sees only its top-level ports.
`timescale 1ns/10ps
module vih_hub_chk (
  input wire logic        CLK_SYS,
  input wire logic        RSTN,
  input wire logic        WAKE_PIN,
  input wire logic [31:0] VTOR_IN,
  input wire logic        VTOR_WR,
  input wire logic        VEC_ACK,
  input wire logic        EOI,
  input wire logic        IRQ_REQ,
  input wire logic [5:0]  IRQ_VEC,
  input wire logic [31:0] VEC_ADDR,
  input wire logic [1:0]  CUR_PRIO,
  input wire logic [24:0] PIN_PULLUP,
  input wire logic [24:0] PIN_OE,
  input wire logic        DPD_ACTIVE,
  input wire logic        CHIP_RST
);
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  logic [31:0] base_reg;
  // Power-down keeps the base against the ordinary reset
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN && !DPD_ACTIVE) base_reg <= vih_pkg::VTOR_RST;
    else if (VTOR_WR) base_reg <= VTOR_IN;
  end
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  pull_state_a: assert property (PIN_PULLUP == '1 && PIN_OE == '0)
    else $error("pins not pulled-up inputs");
  vec_range_a: assert property (IRQ_REQ |-> IRQ_VEC inside
    {[6'h02:6'h05], [6'h10:6'h2F]}) else $error("vector out of range");
  req_hold_a: assert property (IRQ_REQ && !VEC_ACK |=> IRQ_REQ)
    else $error("request withdrawn before take");
  ack_drop_a: assert property (IRQ_REQ && VEC_ACK |=> !IRQ_REQ)
    else $error("request stays after take");
  ack_prio_a: assert property (IRQ_REQ && VEC_ACK |=> ##1
    CUR_PRIO < $past(CUR_PRIO)) else $error("taken below running level");
  eoi_idle_a: assert property (EOI |=> ##1 CUR_PRIO == 2'h3)
    else $error("level not idle after service end");
  vec_addr_a: assert property (IRQ_REQ |->
    VEC_ADDR == base_reg + {IRQ_VEC, 2'h0}) else $error("bad vector addr");
  chip_rst_a: assert property ($rose(RSTN) && !DPD_ACTIVE |->
    CHIP_RST ##1 !CHIP_RST) else $error("chip reset not released");
  wake_rst_a: assert property (DPD_ACTIVE && !WAKE_PIN && !CHIP_RST |->
    ##[1:3] CHIP_RST) else $error("wake gave no chip reset");
  wake_exit_a: assert property (DPD_ACTIVE && !WAKE_PIN |->
    ##[1:3] !DPD_ACTIVE) else $error("wake did not leave power-down");
  cover property (IRQ_REQ && VEC_ACK);
  cover property (EOI);
  cover property ($fell(DPD_ACTIVE));
endmodule : vih_hub_chk

bind vih_hub vih_hub_chk i_vih_hub_chk (.CLK_SYS(CLK_SYS), .RSTN(RSTN),
  .WAKE_PIN(WAKE_PIN), .VTOR_IN(VTOR_IN), .VTOR_WR(VTOR_WR),
  .VEC_ACK(VEC_ACK), .EOI(EOI), .IRQ_REQ(IRQ_REQ), .IRQ_VEC(IRQ_VEC),
  .VEC_ADDR(VEC_ADDR), .CUR_PRIO(CUR_PRIO), .PIN_PULLUP(PIN_PULLUP),
  .PIN_OE(PIN_OE), .DPD_ACTIVE(DPD_ACTIVE), .CHIP_RST(CHIP_RST));

// ===== tb/tb.sv
// Self-checking bench for the vectored interrupt hub.
// Inputs change at the falling edge; a core model takes vectors.
`timescale 1ns/10ps
module tb;
  logic         clk = 1'h0, rstn = 1'h0, wake = 1'h1, dpd_req = 1'h0;
  logic         vtor_wr = 1'h0, hold = 1'h0, ack, eoi, req, dpd, crst;
  logic [1:0]   lag = 2'h0, cprio;
  logic [3:0]   exc = 4'h0;
  logic [5:0]   vec;
  logic [24:0]  pin = '0, pclr = '0, pup, poe;
  logic [31:0]  en = '0, sset = '0, sclr = '0, vtor = '0, pend, vaddr;
  logic [49:0]  sense = '0;
  logic [63:0]  prio = '0;
  logic [151:0] psrc = '0;
  logic [4:0]   ssel [13] = '{default: 5'h05};
  int           n_errors = 0, n_compared = 0, k;

  always #25 clk = ~clk;

  vih_hub i_vih_hub (.CLK_SYS(clk), .RSTN(rstn), .WAKE_PIN(wake),
    .DPD_REQ(dpd_req), .EXC_REQ(exc), .PERIPH_SRC(psrc), .PIN_IN(pin),
    .PIN_SENSE(sense), .PIN_CLR(pclr), .START_SEL(ssel), .IRQ_EN(en),
    .SW_SET(sset), .SW_CLR(sclr), .IRQ_PRIO(prio), .VTOR_IN(vtor),
    .VTOR_WR(vtor_wr), .VEC_ACK(ack), .EOI(eoi), .IRQ_REQ(req),
    .IRQ_VEC(vec), .VEC_ADDR(vaddr), .CUR_PRIO(cprio), .PEND_OUT(pend),
    .PIN_PULLUP(pup), .PIN_OE(poe), .DPD_ACTIVE(dpd), .CHIP_RST(crst));
  vih_core_model i_vih_core_model (.clk(clk), .rst_n(rstn),
    .irq_req(req), .hold(hold), .lag(lag), .vec_ack(ack), .eoi(eoi));

  // ------------------------------------------------------------
  // Access and compare tasks
  // ------------------------------------------------------------
  task automatic conclude();
    if (n_errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask : step
  task automatic take(input logic [5:0] v);
    int i;
    i = 0;
    while (ack !== 1'h1 && i < 60) begin
      step(1);
      i++;
    end
    if (i == 60) begin
      n_errors++;
      conclude();
    end
    chk("vector", vec, v);
    chk("address", vaddr, vtor + {v, 2'h0});
    step(1);
  endtask : take

  initial begin
    step(16);
    rstn = 1'h1;
    step(2);
    chk("prio idle", cprio, 2'h3);
    chk("pull-up", pup, 25'h1FFFFFF);
    chk("out enable", poe, 25'h0);
    chk("chip rst", crst, 1'h0);
    for (k = 0; k < 8; k++) begin
      psrc[17*k] = 1'h1;
      step(3);
      chk("periph pend", pend, 32'h1 << (13 + 2*k));
      chk("no request", req, 1'h0);
      psrc = '0;
      sclr = 32'h1 << (13 + 2*k);
      step(1);
      sclr = '0;
      step(3);
      chk("periph clr", pend, 32'h0);
    end
    for (k = 0; k < 4; k++) begin
      sense[11:10] = k[1:0];
      pin[5] = (k == 2);
      pclr[5] = 1'h1;
      sclr = 32'h0000_1FFF;
      step(3);
      pclr[5] = 1'h0;
      sclr = '0;
      step(3);
      chk("pin idle", pend, 32'h0);
      pin[5] = (k != 2);
      step(3);
      chk("pin set", pend, 32'h1FFF);
      pin[5] = (k == 2);
      step(1);
      sclr = 32'h0000_1FFF;
      step(1);
      sclr = '0;
      step(3);
      chk("pin hold", pend[0], k != 0);
      pclr[5] = 1'h1;
      sclr = 32'h0000_1FFF;
      step(3);
      pclr[5] = 1'h0;
      sclr = '0;
      step(3);
      chk("pin clr", pend, 32'h0);
    end
    ssel[12] = 5'h18;
    pin[24] = 1'h1;
    step(3);
    chk("start 12", pend, 32'h1000);
    pin[24] = 1'h0;
    sclr = 32'h0000_1000;
    vtor = 32'h0000_4000;
    vtor_wr = 1'h1;
    step(1);
    vtor_wr = 1'h0;
    sclr = '0;
    prio[53:40] = 14'h3402;
    en = 32'h0610_0000;
    hold = 1'h1;
    sset = 32'h0610_0000;
    step(1);
    sset = '0;
    step(4);
    chk("top vector", vec, 6'h29);
    hold = 1'h0;
    take(6'h29);
    take(6'h24);
    step(12);
    chk("masked", req, 1'h0);
    chk("masked pend", pend, 32'h0400_0000);
    chk("prio back", cprio, 2'h3);
    sclr = 32'h0400_0000;
    lag = 2'h3;
    sset = 32'h0010_0000;
    step(1);
    sclr = '0;
    sset = '0;
    exc[0] = 1'h1;
    take(6'h02);
    exc[0] = 1'h0;
    take(6'h24);
    step(10);
    dpd_req = 1'h1;
    step(1);
    dpd_req = 1'h0;
    step(2);
    chk("dpd", dpd, 1'h1);
    rstn = 1'h0;
    step(3);
    rstn = 1'h1;
    step(2);
    chk("dpd kept", dpd, 1'h1);
    chk("rst kept", crst, 1'h0);
    wake = 1'h0;
    step(1);
    chk("wake rst", crst, 1'h1);
    step(3);
    chk("wake exit", dpd, 1'h0);
    wake = 1'h1;
    step(4);
    conclude();
  end
endmodule : tb
